// ### verilog/syndrome_pkg.sv
// Constants, offsets and types shared by the fault syndrome capture block.
package syndrome_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned ADR_W       = 8;
  localparam int unsigned VA_W        = 48;
  localparam int unsigned BANK_W      = 8;
  localparam int unsigned BANK_IMPL_W = 4;
  localparam int unsigned COUNT_W     = 8;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [ADR_W-1:0] OFS_FAULT_ADDR_LO = 8'h60;
  localparam logic [ADR_W-1:0] OFS_FAULT_ADDR_HI = 8'h64;
  localparam logic [ADR_W-1:0] OFS_PRIMARY       = 8'h68;
  localparam logic [ADR_W-1:0] OFS_SECONDARY     = 8'h6c;
  localparam logic [ADR_W-1:0] OFS_IPA_LO        = 8'h70;
  localparam logic [ADR_W-1:0] OFS_IPA_HI        = 8'h74;
  localparam logic [ADR_W-1:0] OFS_STATUS        = 8'h78;
  localparam logic [ADR_W-1:0] OFS_CONTROL       = 8'h7c;

  // ----------------------------------------------------------------------
  // Primary syndrome field positions and masks
  // ----------------------------------------------------------------------
  localparam int unsigned BANK_LSB     = 16;
  localparam int unsigned ASYNC_BIT    = 11;
  localparam int unsigned WALK_EXT_BIT = 10;
  localparam int unsigned TRANS_OP_BIT = 9;
  localparam int unsigned SECURITY_BIT = 8;
  localparam int unsigned INSTR_BIT    = 6;
  localparam int unsigned PRIV_BIT     = 5;
  localparam int unsigned DIR_BIT      = 4;
  localparam int unsigned S1_WALK_BIT  = 3;
  localparam int unsigned NESTED_BIT   = 2;
  localparam int unsigned LEVEL_LSB    = 0;
  localparam logic [DATA_W-1:0] PRIMARY_WMASK = 32'h000f0f7f;
  localparam logic [DATA_W-1:0] NESTED_MASK   = 32'h00ff000c;
  localparam logic [DATA_W-1:0] RESET_ZERO    = 32'h00000000;
  localparam logic [DATA_W-1:0] ALL_ONES      = 32'hffffffff;

  // ----------------------------------------------------------------------
  // Secondary syndrome, status and control layouts
  // ----------------------------------------------------------------------
  localparam int unsigned SEC_KIND_LSB   = 0;
  localparam int unsigned SEC_ATOMIC_BIT = 3;
  localparam int unsigned ST_PENDING_BIT = 0;
  localparam int unsigned ST_NESTCAP_BIT = 1;
  localparam int unsigned ST_OVERRUN_BIT = 2;
  localparam int unsigned ST_COUNT_LSB   = 8;
  localparam int unsigned CTL_ENABLE_BIT = 0;
  localparam int unsigned CTL_HOLD_BIT   = 1;
  localparam logic [1:0]  CTL_RESET      = 2'b01;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  localparam logic [1:0] LEVEL_1 = 2'b01;

  typedef enum logic [2:0] {
    FK_TRANSLATION = 3'b000,
    FK_ACCESS      = 3'b001,
    FK_PERMISSION  = 3'b010,
    FK_EXTERNAL    = 3'b011,
    FK_ADDR_SIZE   = 3'b100,
    FK_OTHER       = 3'b101
  } fault_kind_t;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;

endpackage : syndrome_pkg

// ### verilog/fault_rec_if.sv
// Interface joining the capture block to its level encoder and address store.
`timescale 1ns/10ps
interface fault_rec_if;
  import syndrome_pkg::*;
  logic              cap;
  logic              nested;
  logic [VA_W-1:0]   va;
  logic [VA_W-1:0]   ipa;
  logic [VA_W-1:0]   far;
  logic [VA_W-1:0]   ipafar;
  fault_kind_t       kind;
  logic              walk;
  logic [1:0]        walk_lvl;
  logic [1:0]        final_lvl;
  logic              walk_dis;
  logic              out_rng;
  logic [1:0]        level;

  modport top (output cap, nested, va, ipa, kind, walk, walk_lvl, final_lvl, walk_dis, out_rng,
               input far, ipafar, level);
  modport enc (input kind, walk, walk_lvl, final_lvl, walk_dis, out_rng, output level);
  modport adr (input cap, nested, va, ipa, output far, ipafar);
endinterface : fault_rec_if

// ### verilog/fault_level_encode.sv
// Works out the walk level that a fault is reported against.
`timescale 1ns/10ps
module fault_level_encode
  import syndrome_pkg::*;
(
  fault_rec_if.enc rec
);

  // ----------------------------------------------------------------------
  // Level selection
  // ----------------------------------------------------------------------
  function automatic logic [1:0] pick_level(input fault_kind_t kind, input logic walk,
                                            input logic [1:0] walk_lvl, input logic [1:0] final_lvl,
                                            input logic dis, input logic rng);
    logic [1:0] lvl;
    lvl = walk_lvl;
    if (walk) begin
      lvl = walk_lvl;
    end else if (kind == FK_TRANSLATION) begin
      lvl = (dis || rng) ? LEVEL_1 : walk_lvl;
    end else if (kind == FK_ACCESS) begin
      lvl = walk_lvl;
    end else if (kind == FK_PERMISSION) begin
      lvl = final_lvl;
    end
    return lvl;
  endfunction : pick_level

  // Level 0 passes through untouched, so a walk that starts at level 0 is reported as such.
  assign rec.level = pick_level(rec.kind, rec.walk, rec.walk_lvl, rec.final_lvl,
                                rec.walk_dis, rec.out_rng);

endmodule : fault_level_encode

// ### verilog/fault_addr_store.sv
// Holds the fault address and intermediate fault address of the recorded fault.
`timescale 1ns/10ps
module fault_addr_store
  import syndrome_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  fault_rec_if.adr  rec
);

  logic [VA_W-1:0] far_q;
  logic [VA_W-1:0] ipafar_q;

  // ----------------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      far_q    <= '0;
      ipafar_q <= '0;
    end else if (ce_i && rec.cap) begin
      far_q    <= rec.nested ? rec.va : rec.ipa;
      ipafar_q <= rec.ipa;
    end
  end

  assign rec.far    = far_q;
  assign rec.ipafar = ipafar_q;

endmodule : fault_addr_store

// ### verilog/translation_fault_syndrome.sv
// Fault syndrome capture for a stage-2 translation context bank.
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
// What this block does
// - Nested fault stores the stage-1 bank index in bits 23:16.
// - Only the low bank index bits are stored; the rest read zero.
// - Without nested support the bank index reads zero and ignores writes.
// - Bit 11 is 1 for an asynchronous record, 0 for synchronous.
// - Bit 10 is set only for an external fault during table access.
// - Bit 9 is set when an address translation operation faulted.
// - Bit 8 is 0 for a Secure and 1 for a Non-secure transaction.
// - Bit 7 reads zero and discards writes.
// - Bit 6 is 0 for data access, 1 for instruction fetch.
// - Bit 5 is 0 for unprivileged, 1 for privileged access.
// - Bit 4 is 0 for a read, 1 for a write.
// - Far atomic shows the missing permission; read if both or other fault.
// - Bit 3 marks a fault in stage-2 translation of a stage-1 walk.
// - Bit 2 is 1 for nested translation, 0 for stage-2 only.
// - Fault address holds IPA or VA by nesting; IPA register holds IPA.
// - Bits 1:0 give the walk level, codes 0 to 3.
// - Walk and translation faults give the walk level; disabled or unmatched gives 1.
// - Access faults give the faulting level; permission faults the final level.
// - The secondary syndrome register is 32 bits of local layout.
// - Both syndrome registers are read and written by software.
module translation_fault_syndrome
  import syndrome_pkg::*;
#(
  parameter bit NESTED_SUPPORT = 1'b1
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADR_W-1:0]  adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [DATA_W-1:0] dat_i,
  output logic      [DATA_W-1:0] dat_o,
  output logic                   ack_o,
  output logic                   err_o,
  input  wire logic              fault_valid_i,
  input  wire logic              fault_nested_i,
  input  wire logic [BANK_W-1:0] fault_s1_bank_i,
  input  wire logic              fault_async_i,
  input  wire logic              fault_table_access_i,
  input  wire logic              fault_trans_op_i,
  input  wire logic              fault_nonsecure_i,
  input  wire logic              fault_instr_i,
  input  wire logic              fault_priv_i,
  input  wire logic              fault_write_i,
  input  wire logic              fault_atomic_i,
  input  wire logic              fault_rd_missing_i,
  input  wire logic              fault_wr_missing_i,
  input  wire logic              fault_s1_walk_i,
  input  wire logic [2:0]        fault_kind_i,
  input  wire logic [1:0]        fault_walk_level_i,
  input  wire logic [1:0]        fault_final_level_i,
  input  wire logic              fault_walk_disabled_i,
  input  wire logic              fault_out_of_range_i,
  input  wire logic [VA_W-1:0]   fault_va_i,
  input  wire logic [VA_W-1:0]   fault_ipa_i,
  output logic                   fault_pending_o,
  output logic      [1:0]        fault_walk_level_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Byte-lane merge of a write into a register, limited to its writable bits.
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                               input logic [DATA_W-1:0] new_v,
                                               input logic [3:0] sel,
                                               input logic [DATA_W-1:0] mask);
    logic [DATA_W-1:0] lanes;
    lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & mask;
    return (old_v & ~lanes) | (new_v & lanes);
  endfunction : merge

  // Writable bits of the primary register; nested-only fields drop out without support.
  localparam logic [DATA_W-1:0] PRIM_MASK =
    NESTED_SUPPORT ? PRIMARY_WMASK : (PRIMARY_WMASK & ~NESTED_MASK);

  // ----------------------------------------------------------------------
  // Shared record and sub-blocks
  // ----------------------------------------------------------------------
  fault_rec_if rec ();

  logic cap_en;

  fault_level_encode u_level (
    .rec (rec.enc)
  );

  fault_addr_store u_addr (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .rec   (rec.adr)
  );

  assign rec.cap       = cap_en;
  assign rec.nested    = fault_nested_i && NESTED_SUPPORT;
  assign rec.va        = fault_va_i;
  assign rec.ipa       = fault_ipa_i;
  assign rec.kind      = fault_kind_t'(fault_kind_i);
  assign rec.walk      = fault_s1_walk_i || (fault_table_access_i && rec.kind == FK_EXTERNAL);
  assign rec.walk_lvl  = fault_walk_level_i;
  assign rec.final_lvl = fault_final_level_i;
  assign rec.walk_dis  = fault_walk_disabled_i;
  assign rec.out_rng   = fault_out_of_range_i;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  bus_state_t        bus_q;
  logic              req;
  logic              wr_req;
  logic              hit_prim;
  logic              hit_sec;
  logic              hit_stat;
  logic              hit_ctl;
  logic              mapped;

  assign req    = cyc_i && stb_i && (bus_q == BUS_IDLE);
  assign wr_req = req && we_i && ce_i;

  always_comb begin
    hit_prim = 1'b0;
    hit_sec  = 1'b0;
    hit_stat = 1'b0;
    hit_ctl  = 1'b0;
    mapped   = 1'b1;
    if (adr_i == OFS_PRIMARY) begin
      hit_prim = 1'b1;
    end else if (adr_i == OFS_SECONDARY) begin
      hit_sec = 1'b1;
    end else if (adr_i == OFS_STATUS) begin
      hit_stat = 1'b1;
    end else if (adr_i == OFS_CONTROL) begin
      hit_ctl = 1'b1;
    end else if (adr_i == OFS_FAULT_ADDR_LO || adr_i == OFS_FAULT_ADDR_HI) begin
      mapped = 1'b1;
    end else if (adr_i == OFS_IPA_LO || adr_i == OFS_IPA_HI) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  logic [1:0] ctl_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= CTL_RESET;
    end else if (wr_req && hit_ctl && sel_i[0]) begin
      ctl_q <= dat_i[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Capture qualification
  // ----------------------------------------------------------------------
  logic pend_q;

  // With hold set, the first fault is kept until software clears the pending flag.
  assign cap_en = fault_valid_i && ctl_q[CTL_ENABLE_BIT] && !(ctl_q[CTL_HOLD_BIT] && pend_q);

  // ----------------------------------------------------------------------
  // Primary syndrome fields
  // ----------------------------------------------------------------------
  logic              dir_bit;
  logic [DATA_W-1:0] prim_new;
  logic [DATA_W-1:0] prim_q;

  always_comb begin
    if (fault_atomic_i) begin
      dir_bit = (rec.kind == FK_PERMISSION) && fault_wr_missing_i && !fault_rd_missing_i;
    end else begin
      dir_bit = fault_write_i;
    end
  end

  always_comb begin
    prim_new                                     = RESET_ZERO;
    if (rec.nested) begin
      prim_new[BANK_LSB +: BANK_IMPL_W]          = fault_s1_bank_i[BANK_IMPL_W-1:0];
    end
    prim_new[ASYNC_BIT]                          = fault_async_i;
    prim_new[WALK_EXT_BIT]                       = fault_table_access_i && rec.kind == FK_EXTERNAL;
    prim_new[TRANS_OP_BIT]                       = fault_trans_op_i;
    prim_new[SECURITY_BIT]                       = fault_nonsecure_i;
    prim_new[INSTR_BIT]                          = fault_instr_i;
    prim_new[PRIV_BIT]                           = fault_priv_i;
    prim_new[DIR_BIT]                            = dir_bit;
    prim_new[S1_WALK_BIT]                        = fault_s1_walk_i && NESTED_SUPPORT;
    prim_new[NESTED_BIT]                         = rec.nested;
    prim_new[LEVEL_LSB +: 2]                     = rec.level;
  end

  // A fault in the same cycle as a software write wins, so the record stays whole.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prim_q <= RESET_ZERO;
    end else if (ce_i && cap_en) begin
      prim_q <= prim_new & PRIM_MASK;
    end else if (wr_req && hit_prim) begin
      prim_q <= merge(prim_q, dat_i, sel_i, PRIM_MASK);
    end
  end

  // ----------------------------------------------------------------------
  // Secondary syndrome
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] sec_new;
  logic [DATA_W-1:0] sec_q;

  always_comb begin
    sec_new                         = RESET_ZERO;
    sec_new[SEC_KIND_LSB +: 3]      = fault_kind_i;
    sec_new[SEC_ATOMIC_BIT]         = fault_atomic_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sec_q <= RESET_ZERO;
    end else if (ce_i && cap_en) begin
      sec_q <= sec_new;
    end else if (wr_req && hit_sec) begin
      sec_q <= merge(sec_q, dat_i, sel_i, ALL_ONES);
    end
  end

  // ----------------------------------------------------------------------
  // Status: pending, overrun and fault count
  // ----------------------------------------------------------------------
  logic               ovr_q;
  logic [COUNT_W-1:0] cnt_q;
  logic               clr_pend;
  logic               clr_ovr;

  assign clr_pend = wr_req && hit_stat && sel_i[0] && dat_i[ST_PENDING_BIT];
  assign clr_ovr  = wr_req && hit_stat && sel_i[0] && dat_i[ST_OVERRUN_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
    end else if (ce_i && cap_en) begin
      pend_q <= 1'b1;
    end else if (clr_pend) begin
      pend_q <= 1'b0;
    end
  end

  // Lost faults while a record is held are flagged rather than silently dropped.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovr_q <= 1'b0;
    end else if (ce_i && fault_valid_i && pend_q) begin
      ovr_q <= 1'b1;
    end else if (clr_ovr) begin
      ovr_q <= 1'b0;
    end
  end

  // The counter saturates so that software can tell a burst from a wrap.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (ce_i && cap_en && cnt_q != '1) begin
      cnt_q <= cnt_q + COUNT_W'(1);
    end
  end

  logic [DATA_W-1:0] stat_word;

  always_comb begin
    stat_word                          = RESET_ZERO;
    stat_word[ST_PENDING_BIT]          = pend_q;
    stat_word[ST_NESTCAP_BIT]          = NESTED_SUPPORT;
    stat_word[ST_OVERRUN_BIT]          = ovr_q;
    stat_word[ST_COUNT_LSB +: COUNT_W] = cnt_q;
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] rd_word;

  always_comb begin
    rd_word = RESET_ZERO;
    if (hit_prim) begin
      rd_word = prim_q;
    end else if (hit_sec) begin
      rd_word = sec_q;
    end else if (hit_stat) begin
      rd_word = stat_word;
    end else if (hit_ctl) begin
      rd_word = {30'h00000000, ctl_q};
    end else if (adr_i == OFS_FAULT_ADDR_LO) begin
      rd_word = rec.far[DATA_W-1:0];
    end else if (adr_i == OFS_FAULT_ADDR_HI) begin
      rd_word = {16'h0000, rec.far[VA_W-1:DATA_W]};
    end else if (adr_i == OFS_IPA_LO) begin
      rd_word = rec.ipafar[DATA_W-1:0];
    end else if (adr_i == OFS_IPA_HI) begin
      rd_word = {16'h0000, rec.ipafar[VA_W-1:DATA_W]};
    end
  end

  // ----------------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------------
  // One cycle of latency, then a forced idle cycle so ack never stays high twice.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q <= BUS_IDLE;
    end else if (ce_i) begin
      case (bus_q)
        BUS_IDLE: begin
          if (cyc_i && stb_i) begin
            bus_q <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          bus_q <= BUS_IDLE;
        end
        default: begin
          bus_q <= BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end else if (ce_i) begin
      ack_o <= req && mapped;
      err_o <= req && !mapped;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= RESET_ZERO;
    end else if (ce_i && req) begin
      dat_o <= (mapped && !we_i) ? rd_word : RESET_ZERO;
    end
  end

  // ----------------------------------------------------------------------
  // Side outputs
  // ----------------------------------------------------------------------
  assign fault_pending_o    = pend_q;
  assign fault_walk_level_o = prim_q[LEVEL_LSB +: 2];

endmodule : translation_fault_syndrome

// ### tb/translation_fault_syndrome_chk.sv
// Port-level assertions for the fault syndrome capture block.
`timescale 1ns/10ps
module translation_fault_syndrome_chk
  import syndrome_pkg::*;
(
  input wire logic              clk_i, rst_i, ce_i, cyc_i, stb_i, we_i,
  input wire logic [ADR_W-1:0]  adr_i,
  input wire logic [3:0]        sel_i,
  input wire logic [DATA_W-1:0] dat_i, dat_o,
  input wire logic              ack_o, err_o, fault_valid_i, fault_s1_walk_i, fault_table_access_i,
  input wire logic              fault_walk_disabled_i, fault_out_of_range_i, fault_pending_o,
  input wire logic [2:0]        fault_kind_i,
  input wire logic [1:0]        fault_walk_level_i, fault_final_level_i, fault_walk_level_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Tracks whether capture is surely armed, so a refused fault is never mistaken for a miss.
  logic en_q;
  logic take, cap, own;
  assign take = ce_i && cyc_i && stb_i && !ack_o && !err_o;
  assign cap  = fault_valid_i && ce_i && en_q;
  assign own  = !fault_s1_walk_i && !(fault_table_access_i && fault_kind_i == 3'd3);
  always_ff @(posedge clk_i) begin
    if (rst_i) en_q <= 1'b1;
    else if (take && we_i && sel_i[0] && adr_i == 8'h7c) en_q <= dat_i[0] && !dat_i[1];
  end
  property p_answer; take |=> (ack_o ^ err_o); endproperty
  a_answer: assert property (p_answer) else $error("bus request not answered");
  property p_unmapped; take && adr_i[7:5] != 3'b011 |=> err_o && dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_pulse; ack_o && ce_i |=> !ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
  property p_capture; cap |=> fault_pending_o; endproperty
  a_capture: assert property (p_capture) else $error("fault not recorded");
  property p_perm; cap && own && fault_kind_i == 3'd2 |=> fault_walk_level_o == $past(fault_final_level_i); endproperty
  a_perm: assert property (p_perm) else $error("permission fault level wrong");
  property p_forced;
    cap && own && fault_kind_i == 3'd0 && (fault_walk_disabled_i || fault_out_of_range_i)
      |=> fault_walk_level_o == 2'b01;
  endproperty
  a_forced: assert property (p_forced) else $error("forced level one missing");
  property p_access; cap && fault_kind_i == 3'd1 |=> fault_walk_level_o == $past(fault_walk_level_i); endproperty
  a_access: assert property (p_access) else $error("access fault level wrong");
  property p_hold; fault_pending_o && !cyc_i && !fault_valid_i |=> fault_pending_o; endproperty
  a_hold: assert property (p_hold) else $error("record lost without cause");
  property p_steady; !(cyc_i && stb_i) |=> $stable(dat_o); endproperty
  a_steady: assert property (p_steady) else $error("read data changed while idle");
  property p_reset; disable iff (1'b0) rst_i && ce_i |=> !ack_o && !err_o && !fault_pending_o; endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  c_cap: cover property (cap);
  c_err: cover property (err_o);
  c_perm: cover property (cap && fault_kind_i == 3'd2);
endmodule : translation_fault_syndrome_chk
bind translation_fault_syndrome translation_fault_syndrome_chk chk (.*);

// ### tb/testbench.sv
// Self-checking bench for the fault syndrome capture block.
`timescale 1ns/10ps
module testbench
  import syndrome_pkg::*;
;
  logic clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, fault_valid_i = 0;
  logic fault_nested_i = 0, fault_async_i = 0, fault_table_access_i = 0, fault_trans_op_i = 0;
  logic fault_nonsecure_i = 0, fault_instr_i = 0, fault_priv_i = 0, fault_write_i = 0;
  logic fault_atomic_i = 0, fault_rd_missing_i = 0, fault_wr_missing_i = 0, fault_s1_walk_i = 0;
  logic fault_walk_disabled_i = 0, fault_out_of_range_i = 0, ack_o, err_o, fault_pending_o, e;
  logic [7:0]  adr_i = 0, fault_s1_bank_i = 0;
  logic [3:0]  sel_i = 0;
  logic [31:0] dat_i = 0, dat_o, rd, ex;
  logic [2:0]  fault_kind_i = 0;
  logic [1:0]  fault_walk_level_i = 0, fault_final_level_i = 0, fault_walk_level_o;
  logic [47:0] fault_va_i = 0, fault_ipa_i = 0;
  int failures = 0, checked = 0, cycles = 0;
  always #20 clk_i = ~clk_i;
  translation_fault_syndrome DUT (.*);
  task automatic print_verdict();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
    checked++;
    if (seen !== want) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask : chk
  // One classic cycle; the request stands until the edge that samples the answer.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hf};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1 && err_o !== 1'b1);
    r = dat_o;
    er = err_o;
    {cyc_i, stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : bus
  function automatic logic [31:0] exp_prim();
    logic ext, own;
    logic [31:0] v;
    ext = fault_table_access_i && fault_kind_i == 3'd3;
    own = !fault_s1_walk_i && !ext;
    v = '0;
    v[23:16] = fault_nested_i ? {4'h0, fault_s1_bank_i[3:0]} : 8'h00;
    v[11:8] = {fault_async_i, ext, fault_trans_op_i, fault_nonsecure_i};
    v[6:2] = {fault_instr_i, fault_priv_i, fault_atomic_i ? (fault_kind_i == 3'd2 && fault_wr_missing_i &&
              !fault_rd_missing_i) : fault_write_i, fault_s1_walk_i, fault_nested_i};
    v[1:0] = fault_walk_level_i;
    if (own && fault_kind_i == 3'd0 && (fault_walk_disabled_i || fault_out_of_range_i)) v[1:0] = 2'b01;
    if (own && fault_kind_i == 3'd2) v[1:0] = fault_final_level_i;
    return v;
  endfunction : exp_prim
  // The first six records walk through every fault kind, the third as an atomic missing only write; the rest random.
  task automatic fault(input int i);
    fault_valid_i <= 1'b1;
    {fault_nested_i, fault_async_i, fault_table_access_i, fault_trans_op_i, fault_nonsecure_i, fault_instr_i,
     fault_priv_i, fault_write_i, fault_atomic_i, fault_rd_missing_i, fault_wr_missing_i, fault_s1_walk_i,
     fault_walk_disabled_i, fault_out_of_range_i} <= (i == 2) ? {8'($urandom), 6'b101000} : 14'($urandom);
    {fault_s1_bank_i, fault_walk_level_i, fault_final_level_i} <= 12'($urandom);
    fault_va_i <= 48'({$urandom, $urandom});
    fault_ipa_i <= 48'({$urandom, $urandom});
    fault_kind_i <= (i < 6) ? 3'(i) : 3'($urandom_range(5));
    @(posedge clk_i);
    fault_valid_i <= 1'b0;
    @(posedge clk_i);
    ex = exp_prim();
    chk(32'(fault_walk_level_o), 32'(ex[1:0]), "level output");
    bus(1'b0, 8'h68, 32'h0, rd, e);
    chk(rd, ex, "primary");
    bus(1'b0, 8'h6c, 32'h0, rd, e);
    chk(rd, {28'h0, fault_atomic_i, fault_kind_i}, "secondary");
    bus(1'b0, 8'h60, 32'h0, rd, e);
    chk(rd, fault_nested_i ? fault_va_i[31:0] : fault_ipa_i[31:0], "fault address");
    bus(1'b0, 8'h70, 32'h0, rd, e);
    chk(rd, fault_ipa_i[31:0], "ipa address");
  endtask : fault
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(3940));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, 8'h7c, 32'h0, rd, e);
    chk(rd, 32'h1, "control");
    bus(1'b0, 8'h00, 32'h0, rd, e);
    chk({rd[30:0], e}, 32'h1, "unmapped");
    bus(1'b1, 8'h68, 32'hffffffff, rd, e);
    bus(1'b0, 8'h68, 32'h0, rd, e);
    chk(rd, 32'h000f0f7f, "primary mask");
    ex = $urandom;
    bus(1'b1, 8'h6c, ex, rd, e);
    bus(1'b0, 8'h6c, 32'h0, rd, e);
    chk(rd, ex, "secondary rw");
    for (int i = 0; i < 40; i++) fault(i);
    // With hold set, the first fault stays put and a refused one only raises overrun.
    bus(1'b1, 8'h7c, 32'h3, rd, e);
    bus(1'b1, 8'h78, 32'h5, rd, e);
    fault(6);
    fault_valid_i <= 1'b1;
    fault_async_i <= !fault_async_i;
    @(posedge clk_i);
    fault_valid_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, 8'h68, 32'h0, rd, e);
    chk(rd, ex, "held primary");
    bus(1'b0, 8'h78, 32'h0, rd, e);
    chk(rd, 32'h00002907, "status");
    print_verdict();
  end
endmodule : testbench
